// File: rtl/bcc_chip_ctrl.sv
// upper bits 15 to 31 of chip control register with its timers and steering
// Overview of operation
// RULE1: credit update every two freed credits at 0, every one at 1
// RULE2: retry counter expiry sets sticky flag cleared by software write of one
// RULE3: retry limit 00 none, 01 256, 10 64K, 11 2G; reset 00
// RULE4: discard-disable bit turns off discard timer with bridge control enable
// RULE5: short bit gives 64 clocks, else forward or reverse control bit
// RULE6: config retry timer 25us, 0.5ms, 5ms, 25ms; reset code 01
// RULE7: ordering bit 0 allows out-of-order delayed transactions, 1 keeps order
// RULE8: completion timer 50us, 1ms, 10ms, 50ms; reset code 01
// RULE9: isochronous bit 0 tags traffic class 0, else programmed class
// RULE10: three-bit traffic class field resets to 001
// RULE11: loopback only with matching straps in reverse mode; read-only forward
// RULE12: lockout makes primary config get CRS forward or retry reverse
// RULE13: lockout resets to 1 when first test strap high
// RULE14: secondary host must clear lockout after configuring in non-transparent
// RULE15: retry counter restarts when pending transaction completes or changes; code restarts on txnDone, not on a change
`timescale 1ns/1ps
module bcc_chip_ctrl (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        cfgWrite,
    input  wire logic        cfgRead,
    input  wire logic [7:0]  cfgAddr,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic [31:0] cfgWrData,
    input  wire logic        cfgFromPrimary,
    output logic [31:0]      cfgRdData,
    output logic             cfgDone,
    output logic             cfgCrsStatus,
    output logic             cfgTargetRetry,
    input  wire logic        test_strap_a,
    input  wire logic        test_strap_b,
    input  wire logic        test_strap_c,
    input  wire logic        mask_strap_input,
    input  wire logic        reverse_direction_strap,
    input  wire logic        creditFreed,
    output logic             creditUpdate,
    input  wire logic        busRetry,
    input  wire logic        txnDone,
    input  wire logic        discardEnBridge,
    input  wire logic        discardLongFwd,
    input  wire logic        discardLongRev,
    input  wire logic        discardStart,
    input  wire logic        discardStop,
    output logic             discardExpired,
    input  wire logic        cfgRetryStart,
    output logic             cfgRetryExpired,
    input  wire logic        complStart,
    output logic             complExpired,
    input  wire logic [2:0]  fwdTrafficClass,
    output logic [2:0]       txTrafficClass,
    output logic             loopbackOn,
    output logic             strictOrder
);
    typedef struct packed {
        logic [4:0]  strapMeta;
        logic [4:0]  strapSync;
        logic [1:0]  settle;
        logic        fcEvery;
        logic        retryFlag;
        logic [1:0]  retryLim;
        logic        discDis;
        logic        discShort;
        logic [1:0]  cfgRetrySel;
        logic        dtOrder;
        logic [1:0]  complSel;
        logic        isocEn;
        logic [2:0]  isocTc;
        logic        loopback;
        logic        loopOn;
        logic        lockout;
        logic        creditOdd;
        logic        creditUpd;
        logic [31:0] retryCnt;
        logic [31:0] rdData;
        logic        done;
        logic        crs;
        logic        tRetry;
        logic [2:0]  txTc;
    } bcc_ctrl_type;

    bcc_ctrl_type state_ff;
    bcc_ctrl_type nxt_state;
    logic [31:0]  regValue;
    logic         retryHit;
    logic         primaryBlocked;
    logic         regHit;

    function automatic logic [31:0] retry_limit(input logic [1:0] sel);
        case (sel)
            2'h1:    retry_limit = bcc_pkg::RETRY_LIM_256;
            2'h2:    retry_limit = bcc_pkg::RETRY_LIM_64K;
            2'h3:    retry_limit = bcc_pkg::RETRY_LIM_2G;
            default: retry_limit = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic [31:0] four_way(input logic [1:0] sel,
        input int c0, input int c1, input int c2, input int c3);
        case (sel)
            2'h0:    four_way = 32'(c0);
            2'h1:    four_way = 32'(c1);
            2'h2:    four_way = 32'(c2);
            default: four_way = 32'(c3);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register image; low bits belong to another block and read zero
    always_comb
    begin
        regValue = 32'h0000_0000;
        regValue[bcc_pkg::FC_UPDATE_BIT]       = state_ff.fcEvery;
        regValue[bcc_pkg::RETRY_FLAG_BIT]      = state_ff.retryFlag;
        regValue[bcc_pkg::RETRY_LIM_LSB +: 2]  = state_ff.retryLim;
        regValue[bcc_pkg::DISCARD_DIS_BIT]     = state_ff.discDis;
        regValue[bcc_pkg::DISCARD_SHORT_BIT]   = state_ff.discShort;
        regValue[bcc_pkg::CFG_RETRY_LSB +: 2]  = state_ff.cfgRetrySel;
        regValue[bcc_pkg::DT_ORDER_BIT]        = state_ff.dtOrder;
        regValue[bcc_pkg::COMPL_LSB +: 2]      = state_ff.complSel;
        regValue[bcc_pkg::ISOC_EN_BIT]         = state_ff.isocEn;
        regValue[bcc_pkg::ISOC_TC_LSB +: 3]    = state_ff.isocTc;
        regValue[bcc_pkg::LOOPBACK_BIT]        = state_ff.loopback;
        regValue[bcc_pkg::LOCKOUT_BIT]         = state_ff.lockout;
    end

    assign regHit = cfgAddr == bcc_pkg::CHIP_CTRL_OFFSET;
    assign primaryBlocked = cfgFromPrimary && state_ff.lockout; // see RULE12
    assign retryHit = state_ff.retryLim != 2'h0
        && state_ff.retryCnt + 32'h1 == retry_limit(state_ff.retryLim);

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.strapMeta = {test_strap_a, test_strap_b, test_strap_c,
                               mask_strap_input, reverse_direction_strap};
        nxt_state.strapSync = state_ff.strapMeta;
        // lockout waits until both sync flops hold post-reset strap levels
        if (state_ff.settle != 2'h3)
            nxt_state.settle = state_ff.settle + 2'h1;
        if (state_ff.settle == 2'h2)
            nxt_state.lockout = state_ff.strapSync[4]; // see RULE13

        // credit updates
        nxt_state.creditUpd = 1'b0;
        if (creditFreed)
        begin
            if (state_ff.fcEvery || state_ff.creditOdd) // see RULE1
            begin
                nxt_state.creditUpd = 1'b1;
                nxt_state.creditOdd = 1'b0;
            end
            else
                nxt_state.creditOdd = 1'b1;
        end

        // retry counting per pending transaction
        if (txnDone)
            nxt_state.retryCnt = 32'h0; // see RULE15
        else if (busRetry)
            nxt_state.retryCnt = retryHit ? 32'h0 : state_ff.retryCnt + 32'h1;

        // config access
        nxt_state.done   = 1'b0;
        nxt_state.crs    = 1'b0;
        nxt_state.tRetry = 1'b0;
        nxt_state.rdData = 32'h0000_0000;
        if ((cfgRead || cfgWrite) && primaryBlocked)
        begin
            nxt_state.done   = 1'b1;
            nxt_state.crs    = !state_ff.strapSync[0]; // see RULE12
            nxt_state.tRetry = state_ff.strapSync[0];
        end
        else if (cfgRead || cfgWrite)
        begin
            nxt_state.done = 1'b1;
            if (cfgRead && regHit)
                nxt_state.rdData = regValue;
            if (cfgWrite && regHit && cfgByteEn[1])
                nxt_state.fcEvery = cfgWrData[bcc_pkg::FC_UPDATE_BIT];
            if (cfgWrite && regHit && cfgByteEn[2])
            begin
                if (cfgWrData[bcc_pkg::RETRY_FLAG_BIT])
                    nxt_state.retryFlag = 1'b0; // see RULE2
                nxt_state.retryLim = cfgWrData[bcc_pkg::RETRY_LIM_LSB +: 2];
                nxt_state.discDis  = cfgWrData[bcc_pkg::DISCARD_DIS_BIT];
                nxt_state.discShort = cfgWrData[bcc_pkg::DISCARD_SHORT_BIT];
                nxt_state.cfgRetrySel = cfgWrData[bcc_pkg::CFG_RETRY_LSB +: 2];
                nxt_state.dtOrder  = cfgWrData[bcc_pkg::DT_ORDER_BIT];
            end
            if (cfgWrite && regHit && cfgByteEn[3])
            begin
                nxt_state.complSel = cfgWrData[bcc_pkg::COMPL_LSB +: 2];
                nxt_state.isocEn   = cfgWrData[bcc_pkg::ISOC_EN_BIT];
                nxt_state.isocTc   = cfgWrData[bcc_pkg::ISOC_TC_LSB +: 3];
                if (state_ff.strapSync[0]) // see RULE11
                    nxt_state.loopback = cfgWrData[bcc_pkg::LOOPBACK_BIT];
                nxt_state.lockout  = cfgWrData[bcc_pkg::LOCKOUT_BIT];
            end
        end
        // strap pattern: a low, b c mask reverse high
        nxt_state.loopOn = nxt_state.loopback
            && state_ff.strapSync == 5'h0F; // see RULE11
        // set wins over a clear in the same cycle
        if (busRetry && !txnDone && retryHit)
            nxt_state.retryFlag = 1'b1; // see RULE2

        nxt_state.txTc = state_ff.isocEn ? state_ff.isocTc : 3'h0; // see RULE9
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= '0;
            state_ff.retryLim    <= bcc_pkg::RETRY_LIM_RESET; // see RULE3
            state_ff.cfgRetrySel <= bcc_pkg::CFG_RETRY_RESET; // see RULE6
            state_ff.complSel    <= bcc_pkg::COMPL_RESET; // see RULE8
            state_ff.isocTc      <= bcc_pkg::ISOC_TC_RESET; // see RULE10
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timers
    logic [31:0] discLimit;
    logic        discRun;
    assign discLimit = state_ff.discShort ? 32'(bcc_pkg::SHORT_DISCARD_CLKS)
        : (state_ff.strapSync[0] ? discardLongRev : discardLongFwd)
        ? 32'(bcc_pkg::DISCARD_HI_CLKS) : 32'(bcc_pkg::DISCARD_LO_CLKS);
    assign discRun = discardStart && discardEnBridge
        && !state_ff.discDis; // see RULE4

    bcc_timer #(.WIDTH(32)) u_disc (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (discRun),
        .stop     (discardStop),
        .limit    (discLimit), // see RULE5
        .expired  (discardExpired)
    );

    bcc_timer #(.WIDTH(32)) u_cfgr (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (cfgRetryStart),
        .stop     (1'b0),
        .limit    (four_way(state_ff.cfgRetrySel, bcc_pkg::CFG_T0_CYC,
                   bcc_pkg::CFG_T1_CYC, bcc_pkg::CFG_T2_CYC,
                   bcc_pkg::CFG_T3_CYC)), // see RULE6
        .expired  (cfgRetryExpired)
    );

    bcc_timer #(.WIDTH(32)) u_cmpl (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (complStart),
        .stop     (1'b0),
        .limit    (four_way(state_ff.complSel, bcc_pkg::CMP_T0_CYC,
                   bcc_pkg::CMP_T1_CYC, bcc_pkg::CMP_T2_CYC,
                   bcc_pkg::CMP_T3_CYC)), // see RULE8
        .expired  (complExpired)
    );

    assign cfgRdData      = state_ff.rdData;
    assign cfgDone        = state_ff.done;
    assign cfgCrsStatus   = state_ff.crs;
    assign cfgTargetRetry = state_ff.tRetry;
    assign creditUpdate   = state_ff.creditUpd;
    assign txTrafficClass = state_ff.txTc;
    assign loopbackOn     = state_ff.loopOn;
    assign strictOrder = state_ff.dtOrder; // see RULE7

    a_flag_sticky: assert property (@(posedge core_clk) // see RULE2
        disable iff (rst) state_ff.retryFlag && !(cfgWrite && regHit
        && cfgByteEn[2]) |=> state_ff.retryFlag) else $error("flag dropped");
    a_tc_zero: assert property (@(posedge core_clk) // see RULE9
        disable iff (rst) !state_ff.isocEn |=> txTrafficClass == 3'h0)
        else $error("traffic class not zero");
    a_lock_crs: assert property (@(posedge core_clk) // see RULE12
        disable iff (rst) cfgRead && primaryBlocked |=> cfgDone
        && (cfgCrsStatus || cfgTargetRetry)) else $error("lockout ignored");
    a_rev_retry: assert property (@(posedge core_clk) // see RULE12
        disable iff (rst) cfgRead && primaryBlocked && state_ff.strapSync[0]
        |=> cfgTargetRetry && !cfgCrsStatus) else $error("no target retry");
    a_credit_pair: assert property (@(posedge core_clk) // see RULE1
        disable iff (rst) creditFreed && state_ff.fcEvery |=> creditUpdate)
        else $error("credit update missing");
endmodule

// File: shared/bcc_pkg.sv
// constants and types for the chip control upper register bank
package bcc_pkg;
    localparam logic [7:0]  CHIP_CTRL_OFFSET   = 8'h40;
    localparam int          FC_UPDATE_BIT      = 15;
    localparam int          RETRY_FLAG_BIT     = 16;
    localparam int          RETRY_LIM_LSB      = 17;
    localparam int          DISCARD_DIS_BIT    = 19;
    localparam int          DISCARD_SHORT_BIT  = 20;
    localparam int          CFG_RETRY_LSB      = 21;
    localparam int          DT_ORDER_BIT       = 23;
    localparam int          COMPL_LSB          = 24;
    localparam int          ISOC_EN_BIT        = 26;
    localparam int          ISOC_TC_LSB        = 27;
    localparam int          LOOPBACK_BIT       = 30;
    localparam int          LOCKOUT_BIT        = 31;
    localparam logic [1:0]  RETRY_LIM_RESET    = 2'h0;
    localparam logic [1:0]  CFG_RETRY_RESET    = 2'h1;
    localparam logic [1:0]  COMPL_RESET        = 2'h1;
    localparam logic [2:0]  ISOC_TC_RESET      = 3'h1;
    // retry thresholds
    localparam logic [31:0] RETRY_LIM_256      = 32'h0000_0100;
    localparam logic [31:0] RETRY_LIM_64K      = 32'h0001_0000;
    localparam logic [31:0] RETRY_LIM_2G       = 32'h8000_0000;
    localparam int          SHORT_DISCARD_CLKS = 64;
    // long discard limits selected by the bridge control bits
    localparam int          DISCARD_LO_CLKS    = 1024;
    localparam int          DISCARD_HI_CLKS    = 32768;
    // timer times in microseconds, clock 100 MHz
    localparam int          CLK_MHZ            = 100;
    localparam int          CFG_T0_US          = 25;
    localparam int          CFG_T1_US          = 500;
    localparam int          CFG_T2_US          = 5000;
    localparam int          CFG_T3_US          = 25000;
    localparam int          CMP_T0_US          = 50;
    localparam int          CMP_T1_US          = 1000;
    localparam int          CMP_T2_US          = 10000;
    localparam int          CMP_T3_US          = 50000;
    localparam int          CFG_T0_CYC         = CFG_T0_US * CLK_MHZ;
    localparam int          CFG_T1_CYC         = CFG_T1_US * CLK_MHZ;
    localparam int          CFG_T2_CYC         = CFG_T2_US * CLK_MHZ;
    localparam int          CFG_T3_CYC         = CFG_T3_US * CLK_MHZ;
    localparam int          CMP_T0_CYC         = CMP_T0_US * CLK_MHZ;
    localparam int          CMP_T1_CYC         = CMP_T1_US * CLK_MHZ;
    localparam int          CMP_T2_CYC         = CMP_T2_US * CLK_MHZ;
    localparam int          CMP_T3_CYC         = CMP_T3_US * CLK_MHZ;
    typedef enum logic [2:0]
    {
        BCC_IDLE  = 3'h1,
        BCC_RUN   = 3'h2,
        BCC_DONE  = 3'h4
    } bcc_tmr_state_type;
endpackage

// File: rtl/bcc_timer.sv
// one-shot cycle timer with a programmable limit
`timescale 1ns/1ps
module bcc_timer #(
    parameter int WIDTH = 32
)(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic [WIDTH-1:0] limit,
    output logic                  expired
);
    if (WIDTH < 2 || WIDTH > 32)
    begin : g_width_check
        $error("bcc_timer width out of range");
    end

    typedef struct packed {
        bcc_pkg::bcc_tmr_state_type st;
        logic [WIDTH-1:0]           cnt;
        logic                       exp;
    } bcc_tmr_type;

    bcc_tmr_type state_ff;
    bcc_tmr_type nxt_state;

    always_comb
    begin
        nxt_state     = state_ff;
        nxt_state.exp = 1'b0;
        case (state_ff.st)
            bcc_pkg::BCC_IDLE:
            begin
                if (start)
                begin
                    nxt_state.st  = bcc_pkg::BCC_RUN;
                    nxt_state.cnt = '0;
                end
            end
            bcc_pkg::BCC_RUN:
            begin
                nxt_state.cnt = state_ff.cnt + 1'b1;
                if (stop)
                    nxt_state.st = bcc_pkg::BCC_IDLE;
                else if (state_ff.cnt + 1'b1 >= limit)
                begin
                    nxt_state.st  = bcc_pkg::BCC_DONE;
                    nxt_state.exp = 1'b1;
                end
            end
            bcc_pkg::BCC_DONE:
            begin
                if (!start)
                    nxt_state.st = bcc_pkg::BCC_IDLE;
            end
            default:
                nxt_state.st = bcc_pkg::BCC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff.st  <= bcc_pkg::BCC_IDLE;
            state_ff.cnt <= '0;
            state_ff.exp <= 1'b0;
        end
        else
            state_ff <= nxt_state;
    end

    assign expired = state_ff.exp;

    a_expiry_after_run: assert property (@(posedge core_clk) // see RULE5
        disable iff (rst) expired |-> $past(state_ff.st) == bcc_pkg::BCC_RUN)
        else $error("timer expired without running");
endmodule

// File: verif/bcc_far_end.sv
// far-end traffic model: credit returns, bus retries, update count
`timescale 1ns/1ps
module bcc_far_end (
    input  wire logic core_clk,
    input  wire logic creditUpdate,
    output logic      creditFreed,
    output logic      busRetry,
    output logic      txnDone
);
    logic [2:0] drv = 3'h0;
    int         updCount = 0;

    assign {txnDone, busRetry, creditFreed} = drv;

    always @(posedge core_clk)
    begin
        if (creditUpdate === 1'h1)
            updCount <= updCount + 1;
    end

    // kind 0 credit, 1 retry, 2 done; the gap varies so that short
    // and long spacing both reach the counters
    task automatic pulses(input int kind, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge core_clk);
            drv <= 3'(1 << kind);
            @(posedge core_clk);
            drv <= 3'h0;
            repeat (i % 3) @(posedge core_clk);
        end
    endtask
endmodule

// File: verif/tb_top.sv
// self-checking bench for the chip control upper register bank
`timescale 1ns/1ps
module tb_top;
    logic        core_clk, rst, cfgWrite, cfgRead, cfgFromPrimary;
    logic [7:0]  cfgAddr;
    logic [3:0]  cfgByteEn, be;
    logic [31:0] cfgWrData, cfgRdData, rdData, d, cur;
    logic        cfgDone, cfgCrsStatus, cfgTargetRetry, crsSeen, rtySeen;
    logic        test_strap_a, test_strap_b, test_strap_c;
    logic        mask_strap_input, reverse_direction_strap;
    logic        creditFreed, creditUpdate, busRetry, txnDone;
    logic        discardEnBridge, discardLongFwd, discardLongRev;
    logic        discardStart, discardStop, discardExpired;
    logic        cfgRetryStart, cfgRetryExpired, complStart, complExpired;
    logic        loopbackOn, strictOrder;
    logic [2:0]  fwdTrafficClass, txTrafficClass;
    int          seed = 3944;
    int          failCount, samplesChecked, cycles, cnt;
    localparam logic [31:0] UP  = 32'hFFFF_8000;
    localparam logic [31:0] RWM = 32'h3FFE_8000;

    bcc_chip_ctrl bcc_chip_ctrl_i (.core_clk, .rst, .cfgWrite, .cfgRead,
        .cfgAddr, .cfgByteEn, .cfgWrData, .cfgFromPrimary, .cfgRdData,
        .cfgDone, .cfgCrsStatus, .cfgTargetRetry, .test_strap_a,
        .test_strap_b, .test_strap_c, .mask_strap_input,
        .reverse_direction_strap, .creditFreed, .creditUpdate, .busRetry,
        .txnDone, .discardEnBridge, .discardLongFwd, .discardLongRev,
        .discardStart, .discardStop, .discardExpired, .cfgRetryStart,
        .cfgRetryExpired, .complStart, .complExpired, .fwdTrafficClass,
        .txTrafficClass, .loopbackOn, .strictOrder);
    bcc_far_end bcc_far_end_i (.core_clk, .creditUpdate, .creditFreed,
        .busRetry, .txnDone);

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic logic [31:0] rst_val(input logic a);
        return {a, 1'h0, 3'h1, 1'h0, 2'h1, 1'h0, 2'h1, 6'h0, 15'h0};
    endfunction
    function automatic logic [31:0] lanes(input logic [3:0] b);
        return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction
    function automatic logic [2:0] exp_tc(input logic [31:0] v);
        return v[26] ? v[29:27] : 3'h0;
    endfunction
    function automatic logic [31:0] near(input int c, input int n);
        return 32'(c >= n - 4 && c <= n + 4);
    endfunction

    task automatic do_reset(input logic a, input logic rev);
        test_strap_a <= a;
        reverse_direction_strap <= rev;
        rst <= 1'h1;
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
        repeat (5) @(posedge core_clk);
    endtask

    task automatic cfg(input logic w, input logic p, input logic [3:0] b,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        cfgWrite <= w;
        cfgRead <= ~w;
        cfgFromPrimary <= p;
        cfgByteEn <= b;
        cfgWrData <= wd;
        @(posedge core_clk);
        cfgWrite <= 1'h0;
        cfgRead <= 1'h0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (cfgDone !== 1'h1 && n < 4);
        rdData = cfgRdData;
        crsSeen = cfgCrsStatus;
        rtySeen = cfgTargetRetry;
        check("answer delay", 32'(n), 32'h1);
    endtask
    task automatic wr(input logic [31:0] v);
        cfg(1'h1, 1'h0, 4'hF, v);
    endtask
    task automatic rd(input logic p);
        cfg(1'h0, p, 4'hF, 32'h0);
    endtask

    // kind 0 config retry, 1 completion, 2 discard
    task automatic timer(input int kind, input int lim);
        logic x;
        cnt = 0;
        @(posedge core_clk);
        {discardStart, complStart, cfgRetryStart} <= 3'(1 << kind);
        do
        begin
            @(posedge core_clk);
            cnt++;
            x = kind == 0 ? cfgRetryExpired :
                kind == 1 ? complExpired : discardExpired;
        end
        while (x !== 1'h1 && cnt < lim);
        {discardStart, complStart, cfgRetryStart, discardStop} <= 4'h1;
        @(posedge core_clk);
        discardStop <= 1'h0;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failCount++;
            complete_run();
        end
    end

    initial
    begin
        {cfgWrite, cfgRead, cfgFromPrimary, cfgByteEn, cfgWrData} = '0;
        {discardLongFwd, discardLongRev, discardStart, discardStop} = '0;
        {cfgRetryStart, complStart, fwdTrafficClass} = '0;
        {test_strap_b, test_strap_c, mask_strap_input} = 3'h7;
        cfgAddr = 8'h40;
        discardEnBridge = 1'h1;
        do_reset(1'h1, 1'h0);
        rd(1'h0);
        check("reset", rdData & UP, rst_val(1'h1));
        check("tc reset", 32'(rdData[29:27]), 32'h1);
        rd(1'h1);
        check("crs fwd", 32'({crsSeen, rtySeen}), 32'h2);
        cfg(1'h1, 1'h1, 4'hF, 32'h0);
        rd(1'h0);
        check("lock kept", 32'(rdData[31]), 32'h1);
        cfgAddr <= 8'h44;
        rd(1'h0);
        check("other addr", rdData, 32'h0);
        cfgAddr <= 8'h40;
        wr(32'h4000_0000);
        rd(1'h1);
        check("open", 32'({crsSeen, rtySeen, rdData[31:30]}), 32'h0);
        check("loop fwd", 32'(loopbackOn), 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            wr(32'(k) << 15);
            bcc_far_end_i.updCount = 0;
            bcc_far_end_i.pulses(0, k ? 7 : 10);
            repeat (8) @(posedge core_clk);
            check("updates", 32'(bcc_far_end_i.updCount), k ? 7 : 5);
        end
        cur = 32'h0000_8000;
        for (int k = 0; k < 8; k++)
        begin
            d = $random(seed) & RWM;
            be = 4'($random(seed));
            fwdTrafficClass <= 3'($random(seed));
            if (k == 0)
            begin
                d = 32'h3C00_0000;
                be = 4'hF;
            end
            cfg(1'h1, 1'h0, be, d);
            cur = (cur & ~lanes(be)) | (d & lanes(be));
            rd(1'h0);
            check("fields", rdData & RWM, cur & RWM);
            check("order", 32'(strictOrder), 32'(cur[23]));
            check("tc", 32'(txTrafficClass), 32'(exp_tc(cur)));
        end
        wr(32'h0002_0000);
        bcc_far_end_i.pulses(1, 200);
        bcc_far_end_i.pulses(2, 1);
        bcc_far_end_i.pulses(1, 255);
        rd(1'h0);
        check("no expiry", 32'(rdData[16]), 32'h0);
        bcc_far_end_i.pulses(1, 5);
        rd(1'h0);
        check("expired", 32'(rdData[16]), 32'h1);
        bcc_far_end_i.pulses(2, 1);
        wr(32'h0002_0000);
        rd(1'h0);
        check("sticky", 32'(rdData[16]), 32'h1);
        wr(32'h0003_0000);
        rd(1'h0);
        check("cleared", 32'(rdData[16]), 32'h0);
        wr(32'h0);
        bcc_far_end_i.pulses(1, 300);
        rd(1'h0);
        check("no limit", 32'(rdData[16]), 32'h0);
        // the tolerance covers start-up pipeline, not a wrong code
        wr(32'h0010_0000);
        timer(2, 200);
        check("short discard", near(cnt, 64), 32'h1);
        wr(32'h0018_0000);
        timer(2, 200);
        check("discard off", 32'(cnt), 32'd200);
        wr(32'h0);
        timer(2, 1100);
        check("long discard", near(cnt, bcc_pkg::DISCARD_LO_CLKS), 32'h1);
        timer(0, 3000);
        check("cfg timer", near(cnt, bcc_pkg::CFG_T0_CYC), 32'h1);
        timer(1, 6000);
        check("cpl timer", near(cnt, bcc_pkg::CMP_T0_CYC), 32'h1);
        wr(32'h0100_0000);
        timer(1, 6000);
        check("cpl code one", 32'(cnt), 32'd6000);
        test_strap_b <= 1'h1;
        do_reset(1'h0, 1'h1);
        rd(1'h1);
        check("no lock", 32'({crsSeen, rtySeen, rdData[31]}), 32'h0);
        cfg(1'h1, 1'h1, 4'hF, 32'h4000_0000);
        repeat (2) @(posedge core_clk);
        check("loop on", 32'(loopbackOn), 32'h1);
        // straps pass two sync flops, so allow time before looking
        test_strap_c <= 1'h0;
        repeat (6) @(posedge core_clk);
        check("loop strap", 32'(loopbackOn), 32'h0);
        test_strap_c <= 1'h1;
        wr(32'hC000_0000);
        rd(1'h1);
        check("retry rev", 32'({crsSeen, rtySeen}), 32'h1);
        complete_run();
    end
endmodule
